// file: verilog/tbas_pkg.sv
// Operation
// - key a 1.5 s stores position one
// - key b 1.5 s stores position two
// - key c 1.5 s stores position three
// - keys a+b 2.5 s clear all positions
// - keys b+c enter tuning, all LEDs on
// - tuning: 0.5 s press picks sequence 1-5
// - no start within 10 s leaves tuning
// - failure or abort erases captured positions
// - double-acting variant allows sequences 1, 2 only
// - sequence 1: capture, valve one, 10 s, return
// - sequence 2: mirror of sequence 1
// - sequence 3: sequence 1 then valve two pass
// - sequence 4: valves two, one, two in turn
// - sequence 5: like 3, intermediate third position
// - 15 s arrival timeout fails the sequence
// - confirmation flash 100 ms on/off, three times
// - untaught flashes fault colour 250 ms
package tbas_pkg;
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;
  localparam int unsigned T_DEBOUNCE_MS   = 10;
  localparam int unsigned T_TEACH_MS      = 1500;
  localparam int unsigned T_RESET_MS      = 2500;
  localparam int unsigned T_TUNE_KEY_MS   = 500;
  localparam int unsigned T_TUNE_IDLE_MS  = 10000;
  localparam int unsigned T_VALVE_WAIT_MS = 10000;
  localparam int unsigned T_ARRIVE_MS     = 15000;
  localparam int unsigned T_FAST_MS       = 100;
  localparam int unsigned T_SLOW_MS       = 250;
  localparam int unsigned DEBOUNCE_CYC_D  = T_DEBOUNCE_MS * CYC_PER_MS;
  localparam int unsigned TEACH_CYC_D     = T_TEACH_MS * CYC_PER_MS;
  localparam int unsigned RESET_CYC_D     = T_RESET_MS * CYC_PER_MS;
  localparam int unsigned TUNE_KEY_CYC_D  = T_TUNE_KEY_MS * CYC_PER_MS;
  localparam int unsigned TUNE_IDLE_CYC_D = T_TUNE_IDLE_MS * CYC_PER_MS;
  localparam int unsigned VALVE_CYC_D     = T_VALVE_WAIT_MS * CYC_PER_MS;
  localparam int unsigned ARRIVE_CYC_D    = T_ARRIVE_MS * CYC_PER_MS;
  localparam int unsigned FAST_CYC_D      = T_FAST_MS * CYC_PER_MS;
  localparam int unsigned SLOW_CYC_D      = T_SLOW_MS * CYC_PER_MS;
  localparam int unsigned KEY_COUNT       = 3;
  localparam int unsigned POS_COUNT       = 3;
  localparam int unsigned LED_COUNT       = 6;
  localparam int unsigned STROKE_W        = 8;
  localparam logic [2:0]  FLASH_LAST_PH   = 3'h5;
  localparam logic [7:0]  ARRIVE_TOL      = 8'h02;
  localparam logic [2:0]  KEY_NONE        = 3'h0;
  localparam logic [2:0]  KEY_A           = 3'h1;
  localparam logic [2:0]  KEY_B           = 3'h2;
  localparam logic [2:0]  KEY_AB          = 3'h3;
  localparam logic [2:0]  KEY_C           = 3'h4;
  localparam logic [2:0]  KEY_AC          = 3'h5;
  localparam logic [2:0]  KEY_BC          = 3'h6;
  localparam logic [5:0]  CHASE_FIRST     = 6'h01;

  typedef enum logic [2:0] {SEQ_NONE, SEQ_1, SEQ_2, SEQ_3, SEQ_4, SEQ_5, SEQ_6} tbas_seq_type;
  typedef enum logic [2:0] {
    ST_NORMAL, ST_TUNE, ST_WAIT_A, ST_WAIT_B, ST_ARRIVE_A, ST_WAIT_C, ST_ARRIVE_B
  } tbas_state_type;

  typedef struct packed {
    logic [2:0] fault;
    logic [2:0] pos;
  } tbas_led_type;

  typedef struct packed {
    logic two;
    logic one;
  } tbas_valve_type;
endpackage : tbas_pkg

// file: verilog/tbas_key_filter.sv
`timescale 1ns/1ns
module tbas_key_filter import tbas_pkg::*; #(
  parameter int unsigned KEYS       = 4,
  parameter int unsigned STABLE_CYC = DEBOUNCE_CYC_D
) (
  // clock and reset
  input  wire logic            i_clk,
  input  wire logic            i_rst_b,
  // raw pins and filtered levels
  input  wire logic [KEYS-1:0] i_key_raw,
  output logic      [KEYS-1:0] o_key
);
  genvar g;
  generate
    for (g = 0; g < KEYS; g++) begin : g_key
      logic        meta_r;
      logic        sync_r;
      logic [31:0] cnt_r;
      always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          meta_r <= 1'b0;
          sync_r <= 1'b0;
        end else begin
          meta_r <= i_key_raw[g];
          sync_r <= meta_r;
        end
      end
      // a level must hold a full window before it counts
      always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          cnt_r    <= '0;
          o_key[g] <= 1'b0;
        end else if (sync_r == o_key[g]) begin
          cnt_r <= '0;
        end else if (cnt_r == 32'(STABLE_CYC - 1)) begin
          cnt_r    <= '0;
          o_key[g] <= sync_r;
        end else begin
          cnt_r <= cnt_r + 32'h1;
        end
      end
    end
  endgenerate
endmodule : tbas_key_filter

// file: verilog/tbas_blink_gen.sv
`timescale 1ns/1ns
module tbas_blink_gen import tbas_pkg::*; #(
  parameter int unsigned SLOW_CYC = SLOW_CYC_D,
  parameter int unsigned STEP_CYC = FAST_CYC_D
) (
  // clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_rst_b,
  // patterns
  output logic                      o_slow,
  output logic      [LED_COUNT-1:0] o_chase
);
  logic [31:0] slow_cnt_r;
  logic [31:0] step_cnt_r;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      slow_cnt_r <= '0;
      o_slow     <= 1'b1;
    end else if (slow_cnt_r == 32'(SLOW_CYC - 1)) begin
      slow_cnt_r <= '0;
      o_slow     <= ~o_slow;
    end else begin
      slow_cnt_r <= slow_cnt_r + 32'h1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      step_cnt_r <= '0;
      o_chase    <= CHASE_FIRST;
    end else if (step_cnt_r == 32'(STEP_CYC - 1)) begin
      step_cnt_r <= '0;
      o_chase    <= {o_chase[LED_COUNT-2:0], o_chase[LED_COUNT-1]};
    end else begin
      step_cnt_r <= step_cnt_r + 32'h1;
    end
  end
endmodule : tbas_blink_gen

// file: verilog/tbas_sequencer.sv
`timescale 1ns/1ns
module tbas_sequencer import tbas_pkg::*; #(
  parameter int unsigned DEBOUNCE_CYC  = DEBOUNCE_CYC_D,
  parameter int unsigned TEACH_CYC     = TEACH_CYC_D,
  parameter int unsigned RESET_CYC     = RESET_CYC_D,
  parameter int unsigned TUNE_KEY_CYC  = TUNE_KEY_CYC_D,
  parameter int unsigned TUNE_IDLE_CYC = TUNE_IDLE_CYC_D,
  parameter int unsigned VALVE_CYC     = VALVE_CYC_D,
  parameter int unsigned ARRIVE_CYC    = ARRIVE_CYC_D,
  parameter int unsigned FAST_CYC      = FAST_CYC_D,
  parameter int unsigned SLOW_CYC      = SLOW_CYC_D
) (
  // clock and reset
  input  wire logic                I_CLK_SYS,
  input  wire logic                I_RST_B,
  // operator pins
  input  wire logic [KEY_COUNT-1:0] I_TEACH_KEY,
  input  wire logic                I_DOUBLE_ACTING,
  // position measurement
  input  wire logic [STROKE_W-1:0] I_STROKE,
  input  wire logic                I_STROKE_VALID,
  // indicators and pilot valves
  output tbas_led_type             O_LED,
  output tbas_valve_type           O_VALVE,
  // taught positions
  output logic      [POS_COUNT-1:0] O_TAUGHT,
  output logic      [STROKE_W-1:0] O_POS_ONE,
  output logic      [STROKE_W-1:0] O_POS_TWO,
  output logic      [STROKE_W-1:0] O_POS_THREE
);
  logic [KEY_COUNT:0]      keys_all;
  logic [KEY_COUNT-1:0]    key, combo_r;
  logic [LED_COUNT-1:0]    chase;
  logic [31:0]             hold_r, thr, tmr_r, flash_tmr_r;
  logic                    dbl, slow_on, fired_r, fire, key_new, tmr_clr, fail, clr_all, running;
  logic                    tgt_two_r, tgt_two_nxt, arrived, flash_fault_r;
  tbas_state_type          st_r, st_nxt;
  tbas_seq_type            seq_r, seq_nxt, pick;
  logic [POS_COUNT-1:0]    cap, teach, store, captured_r, flash_pos_r;
  tbas_valve_type          valve_nxt;
  logic [STROKE_W-1:0]     tgt, diff;
  logic [STROKE_W-1:0]     pos_r [POS_COUNT];
  logic [2:0]              flash_ph_r;
  tbas_led_type            led_nxt;

  tbas_key_filter #(
    .KEYS       (KEY_COUNT + 1),
    .STABLE_CYC (DEBOUNCE_CYC)
  ) u_keys (
    .i_clk     (I_CLK_SYS),
    .i_rst_b   (I_RST_B),
    .i_key_raw ({I_DOUBLE_ACTING, I_TEACH_KEY}),
    .o_key     (keys_all)
  );
  assign key = keys_all[KEY_COUNT-1:0];
  assign dbl = keys_all[KEY_COUNT];

  tbas_blink_gen #(
    .SLOW_CYC (SLOW_CYC),
    .STEP_CYC (FAST_CYC)
  ) u_blink (
    .i_clk   (I_CLK_SYS),
    .i_rst_b (I_RST_B),
    .o_slow  (slow_on),
    .o_chase (chase)
  );

  // hold timing; a combo change restarts the count
  always_comb begin
    if (st_r == ST_TUNE || combo_r == KEY_BC) thr = 32'(TUNE_KEY_CYC);
    else if (combo_r == KEY_AB)               thr = 32'(RESET_CYC);
    else                                      thr = 32'(TEACH_CYC);
  end
  assign fire    = !fired_r && key == combo_r && key != KEY_NONE && hold_r == thr - 32'h1;
  assign key_new = |(key & ~combo_r);

  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      combo_r <= KEY_NONE;
      hold_r  <= '0;
      fired_r <= 1'b0;
    end else begin
      combo_r <= key;
      if (key != combo_r || key == KEY_NONE) begin
        hold_r  <= '0;
        fired_r <= 1'b0;
      end else if (!fired_r) begin
        hold_r  <= hold_r + 32'h1;
        fired_r <= fire;
      end
    end
  end

  always_comb begin
    unique case (combo_r)
      KEY_A:   pick = SEQ_1;
      KEY_B:   pick = SEQ_2;
      KEY_C:   pick = SEQ_3;
      KEY_AB:  pick = SEQ_4;
      KEY_AC:  pick = SEQ_5;
      KEY_BC:  pick = SEQ_6;
      default: pick = SEQ_NONE;
    endcase
  end

  assign tgt     = tgt_two_r ? pos_r[1] : pos_r[0];
  assign diff    = (I_STROKE >= tgt) ? I_STROKE - tgt : tgt - I_STROKE;
  assign arrived = I_STROKE_VALID && diff <= ARRIVE_TOL;

  always_comb begin
    st_nxt      = st_r;
    seq_nxt     = seq_r;
    tmr_clr     = 1'b0;
    cap         = '0;
    fail        = 1'b0;
    valve_nxt   = O_VALVE;
    tgt_two_nxt = tgt_two_r;
    unique case (st_r)
      ST_NORMAL: begin
        if (fire && combo_r == KEY_BC) begin
          st_nxt  = ST_TUNE;
          tmr_clr = 1'b1;
        end
      end
      ST_TUNE: begin
        // spare sequence and, on double-acting units, 3-5 are ignored
        if (fire && pick != SEQ_NONE && pick != SEQ_6 && (!dbl || pick <= SEQ_2)) begin
          st_nxt  = ST_WAIT_A;
          seq_nxt = pick;
          tmr_clr = 1'b1;
          if (pick == SEQ_4) begin
            valve_nxt.two = 1'b1;
          end else begin
            valve_nxt.one = 1'b1;
            cap[pick == SEQ_2] = 1'b1;
          end
        end else if (tmr_r == 32'(TUNE_IDLE_CYC - 1)) begin
          st_nxt = ST_NORMAL;
        end
      end
      ST_WAIT_A: begin
        if (tmr_r == 32'(VALVE_CYC - 1)) begin
          tmr_clr = 1'b1;
          if (seq_r == SEQ_4) begin
            cap[0]    = 1'b1;
            valve_nxt = '{two: 1'b0, one: 1'b1};
            st_nxt    = ST_WAIT_B;
          end else begin
            cap[seq_r != SEQ_2] = 1'b1;
            valve_nxt.one       = 1'b0;
            tgt_two_nxt         = seq_r == SEQ_2;
            st_nxt              = ST_ARRIVE_A;
          end
        end
      end
      ST_WAIT_B: begin
        if (tmr_r == 32'(VALVE_CYC - 1)) begin
          tmr_clr     = 1'b1;
          cap[1]      = 1'b1;
          valve_nxt   = '{two: 1'b1, one: 1'b0};
          tgt_two_nxt = 1'b0;
          st_nxt      = ST_ARRIVE_B;
        end
      end
      ST_ARRIVE_A: begin
        if (arrived) begin
          tmr_clr = 1'b1;
          if (seq_r == SEQ_3 || seq_r == SEQ_5) begin
            valve_nxt.two = 1'b1;
            st_nxt        = ST_WAIT_C;
          end else begin
            st_nxt = ST_NORMAL;
          end
        end else if (tmr_r == 32'(ARRIVE_CYC - 1)) begin
          fail = 1'b1;
        end
      end
      ST_WAIT_C: begin
        if (tmr_r == 32'(VALVE_CYC - 1)) begin
          tmr_clr       = 1'b1;
          cap[2]        = 1'b1;
          valve_nxt.two = 1'b0;
          tgt_two_nxt   = 1'b0;
          st_nxt        = ST_ARRIVE_B;
        end
      end
      ST_ARRIVE_B: begin
        if (arrived) begin
          valve_nxt.two = 1'b0;
          st_nxt        = ST_NORMAL;
        end else if (tmr_r == 32'(ARRIVE_CYC - 1)) begin
          fail = 1'b1;
        end
      end
    endcase
    // a fresh key press aborts; a capture with no valid stroke also fails, except the start capture made in ST_TUNE
    if (running && (key_new || (cap != '0 && !I_STROKE_VALID))) fail = 1'b1;
    if (fail) begin
      st_nxt    = ST_NORMAL;
      valve_nxt = '{two: 1'b0, one: 1'b0};
    end
  end

  assign running = st_r != ST_NORMAL && st_r != ST_TUNE;
  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      st_r      <= ST_NORMAL;
      seq_r     <= SEQ_NONE;
      tmr_r     <= '0;
      tgt_two_r <= 1'b0;
      O_VALVE   <= '{two: 1'b0, one: 1'b0};
    end else begin
      st_r      <= st_nxt;
      seq_r     <= seq_nxt;
      tmr_r     <= tmr_clr ? '0 : tmr_r + 32'h1;
      tgt_two_r <= tgt_two_nxt;
      O_VALVE   <= valve_nxt;
    end
  end

  // teaching from the keys only in normal operation
  assign teach[0] = st_r == ST_NORMAL && fire && combo_r == KEY_A;
  assign teach[1] = st_r == ST_NORMAL && fire && combo_r == KEY_B;
  assign teach[2] = st_r == ST_NORMAL && fire && combo_r == KEY_C;
  assign clr_all  = st_r == ST_NORMAL && fire && combo_r == KEY_AB;
  assign store    = (fail ? '0 : cap) | teach;

  genvar g;
  generate
    for (g = 0; g < POS_COUNT; g++) begin : g_pos
      always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
        if (!I_RST_B) begin
          pos_r[g] <= '0;
        end else if (store[g] && I_STROKE_VALID) begin
          pos_r[g] <= I_STROKE;
        end
      end
    end
  endgenerate
  assign O_POS_ONE   = pos_r[0];
  assign O_POS_TWO   = pos_r[1];
  assign O_POS_THREE = pos_r[2];
  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_TAUGHT   <= '0;
      captured_r <= '0;
    end else if (fail) begin
      O_TAUGHT   <= O_TAUGHT & ~(captured_r | cap);
      captured_r <= '0;
    end else if (clr_all) begin
      O_TAUGHT <= '0;
    end else begin
      O_TAUGHT   <= O_TAUGHT | (store & {POS_COUNT{I_STROKE_VALID}});
      captured_r <= (st_r == ST_TUNE) ? cap : captured_r | cap;
    end
  end

  // three-fold flash; an out-of-range target flashes the fault colour
  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      flash_pos_r   <= '0;
      flash_fault_r <= 1'b0;
      flash_ph_r    <= '0;
      flash_tmr_r   <= '0;
    end else if (teach != '0) begin
      flash_pos_r   <= teach;
      flash_fault_r <= !I_STROKE_VALID;
      flash_ph_r    <= '0;
      flash_tmr_r   <= '0;
    end else if (flash_pos_r != '0) begin
      if (flash_tmr_r == 32'(FAST_CYC - 1)) begin
        flash_tmr_r <= '0;
        flash_ph_r  <= flash_ph_r + 3'h1;
        if (flash_ph_r == FLASH_LAST_PH) flash_pos_r <= '0;
      end else begin
        flash_tmr_r <= flash_tmr_r + 32'h1;
      end
    end
  end

  always_comb begin
    led_nxt = '{fault: 3'h0, pos: 3'h0};
    if (st_r == ST_TUNE) begin
      led_nxt = '{fault: 3'h7, pos: 3'h7};
    end else if (running) begin
      led_nxt = tbas_led_type'(chase);
    end else begin
      for (int k = 0; k < POS_COUNT; k++) begin
        if (flash_pos_r[k]) begin
          if (flash_fault_r) led_nxt.fault[k] = !flash_ph_r[0];
          else               led_nxt.pos[k]   = !flash_ph_r[0];
        end else if (O_TAUGHT[k]) begin
          led_nxt.pos[k] = (k == POS_COUNT - 1) ? slow_on : 1'b1;
        end else begin
          led_nxt.fault[k] = slow_on;
        end
      end
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) O_LED <= '{fault: 3'h0, pos: 3'h0};
    else          O_LED <= led_nxt;
  end
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RST_B);

  sequence start_seq1;
    st_r == ST_TUNE && fire && combo_r == KEY_A;
  endsequence
  sequence wait_full;
    st_r == ST_WAIT_A && tmr_r == 32'(VALVE_CYC - 1);
  endsequence

  teach_one_a: assert property (teach[0] && I_STROKE_VALID |=> O_TAUGHT[0] && O_POS_ONE == $past(I_STROKE))
    else $error("position one not stored");
  teach_two_a: assert property (teach[1] && I_STROKE_VALID |=> O_TAUGHT[1] && O_POS_TWO == $past(I_STROKE))
    else $error("position two not stored");
  teach_three_a: assert property (teach[2] && I_STROKE_VALID |=> O_TAUGHT[2] ##2 O_LED.pos[2] && !O_LED.fault[2])
    else $error("position three not stored");
  clear_all_a: assert property (clr_all |=> O_TAUGHT == '0)
    else $error("taught positions not cleared");
  tune_enter_a: assert property (st_r == ST_NORMAL && fire && combo_r == KEY_BC |=> st_r == ST_TUNE ##1 O_LED == 6'h3F)
    else $error("tuning mode not shown");
  seq_one_start_a: assert property (start_seq1 and !dbl |=> O_VALVE.one && !O_VALVE.two && st_r == ST_WAIT_A)
    else $error("sequence one did not energise valve one");
  dbl_limit_a: assert property (dbl |-> !(st_r == ST_WAIT_A && seq_r > SEQ_2))
    else $error("sequence not allowed on double acting unit");
  wait_end_a: assert property (wait_full and seq_r == SEQ_1 |=> !O_VALVE.one && st_r inside {ST_ARRIVE_A, ST_NORMAL})
    else $error("valve one not released after wait");
  tune_idle_a: assert property (st_r == ST_TUNE && !fire && tmr_r == 32'(TUNE_IDLE_CYC - 1) |=> st_r == ST_NORMAL)
    else $error("tuning mode did not time out");
  arrive_tmo_a: assert property (st_r inside {ST_ARRIVE_A, ST_ARRIVE_B} && !arrived && tmr_r == 32'(ARRIVE_CYC - 1)
    |=> st_r == ST_NORMAL && O_VALVE == 2'h0)
    else $error("arrival timeout not handled");
  fail_erase_a: assert property (fail |=> (O_TAUGHT & $past(captured_r)) == '0)
    else $error("captured positions survived failure");
  flash_len_a: assert property ($rose(flash_pos_r != '0) |-> (flash_pos_r != '0)[*8])
    else $error("confirmation flash cut short");
endmodule : tbas_sequencer

// file: tb/tbas_plant_model.sv
`timescale 1ns/1ns
module tbas_plant_model import tbas_pkg::*; #(
  parameter int unsigned LAG = 3
) (
  // clock and reset
  input  wire logic                i_clk,
  input  wire logic                i_rst_b,
  // pilot valves and hand placement
  input  wire tbas_valve_type      i_valve,
  input  wire logic [1:0]          i_place,
  input  wire logic                i_stuck,
  input  wire logic                i_present,
  // position sensor
  output logic      [STROKE_W-1:0] o_stroke,
  output logic                     o_valid
);
  logic [STROKE_W-1:0] goal;
  logic [STROKE_W-1:0] pos_r;
  logic [STROKE_W-1:0] noise_r;
  int unsigned         lag_r;
  // stuck piston ignores the spring return, so arrival never comes
  always_comb begin
    if (i_valve.one) goal = 8'hC8;
    else if (i_valve.two) goal = 8'h64;
    else if (i_stuck) goal = pos_r;
    else goal = (i_place == 2'h1) ? 8'hC8 : ((i_place == 2'h2) ? 8'h64 : 8'h14);
  end
  // piston starts closed before any sequence
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pos_r <= 8'h14;
      lag_r <= 0;
    end else if (goal != pos_r) begin
      lag_r <= lag_r + 1;
      if (lag_r >= LAG) begin
        pos_r <= goal;
        lag_r <= 0;
      end
    end else begin
      lag_r <= 0;
    end
  end
  // out of range the stroke wanders every cycle
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) noise_r <= 8'h00;
    else noise_r <= noise_r + 8'h35;
  end
  assign o_stroke = i_present ? pos_r : noise_r;
  assign o_valid  = i_present;
endmodule : tbas_plant_model

// file: tb/teach_button_autotune_sequencer_tb_top.sv
`timescale 1ns/1ns
module teach_button_autotune_sequencer_tb_top import tbas_pkg::*;;
  localparam int D = 4, F = 10, S = 20, K = 50, T = 100, R = 150, I = 400, V = 200, A = 300;
  localparam logic [7:0] CL = 8'h14, OP = 8'hC8, MI = 8'h64;
  logic           clk = 1'b0;
  logic           rst_b = 1'b0;
  logic [2:0]     key = 3'h0;
  logic           dbl = 1'b0;
  logic [1:0]     place = 2'h0;
  logic           stuck = 1'b0;
  logic [7:0]     stroke;
  logic           valid;
  tbas_led_type   led;
  tbas_valve_type valve;
  logic [2:0]     taught;
  logic [7:0]     p1;
  logic [7:0]     p2;
  logic [7:0]     p3;
  int             fails = 0;
  int             checks_done = 0;
  always #5 clk = ~clk;
  tbas_sequencer #(.DEBOUNCE_CYC(D), .TEACH_CYC(T), .RESET_CYC(R), .TUNE_KEY_CYC(K), .TUNE_IDLE_CYC(I),
    .VALVE_CYC(V), .ARRIVE_CYC(A), .FAST_CYC(F), .SLOW_CYC(S)) uut (.I_CLK_SYS(clk), .I_RST_B(rst_b),
    .I_TEACH_KEY(key), .I_DOUBLE_ACTING(dbl), .I_STROKE(stroke), .I_STROKE_VALID(valid), .O_LED(led),
    .O_VALVE(valve), .O_TAUGHT(taught), .O_POS_ONE(p1), .O_POS_TWO(p2), .O_POS_THREE(p3));
  tbas_plant_model #(.LAG(3)) plant (.i_clk(clk), .i_rst_b(rst_b), .i_valve(valve), .i_place(place),
    .i_stuck(stuck), .i_present(1'b1), .o_stroke(stroke), .o_valid(valid));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic ran_out();
    fails++;
    $display("unexpected at %0t: wait ran out", $time);
    finish_test();
  endtask : ran_out
  task automatic press(input logic [2:0] k, input int n);
    @(posedge clk);
    key <= k;
    repeat (n) @(posedge clk);
    key <= 3'h0;
    repeat (D + 4) @(posedge clk);
  endtask : press
  task automatic tune(input logic [2:0] k);
    press(3'h6, K + 20);
    press(k, K + 20);
  endtask : tune
  task automatic wait_v(input logic [1:0] v, input int n);
    int i;
    for (i = 0; i < n; i++) begin
      @(posedge clk);
      #1;
      if (valve === v) break;
    end
    if (i == n) ran_out();
  endtask : wait_v
  task automatic wait_t(input int b);
    int i;
    for (i = 0; i < T + 20; i++) begin
      @(posedge clk);
      #1;
      if (taught[b] === 1'b1) break;
    end
    if (i == T + 20) ran_out();
  endtask : wait_t
  // counting lit cycles is immune to the phase of a free blink
  task automatic lit(input int b, input int n, input int e);
    int c;
    c = 0;
    repeat (n) begin
      @(posedge clk);
      #1;
      c += led[b];
    end
    chk(c[7:0], e[7:0]);
  endtask : lit
  task automatic t_teach_a();
    @(posedge clk);
    key <= 3'h1;
    wait_t(0);
    lit(0, 6 * F, 3 * F);
    lit(0, 40, 40);
    chk(p1, CL);
    press(3'h0, 1);
  endtask : t_teach_a
  task automatic t_teach_bc();
    press(3'h2, T - 40);
    chk({5'h0, taught}, 8'h01);
    place <= 2'h1;
    press(3'h2, T + 20);
    chk(p2, OP);
    place <= 2'h2;
    @(posedge clk);
    key <= 3'h4;
    wait_t(2);
    lit(2, 6 * F, 3 * F);
    lit(2, 2 * S, S);
    chk(p3, MI);
    press(3'h0, 1);
    place <= 2'h0;
  endtask : t_teach_bc
  task automatic t_clear();
    press(3'h3, R + 20);
    chk({5'h0, taught}, 8'h00);
    lit(3, 2 * S, S);
    chk({5'h0, led.pos}, 8'h00);
  endtask : t_clear
  task automatic t_idle();
    press(3'h6, K + 20);
    chk({2'h0, led}, 8'h3F);
    repeat (I) @(posedge clk);
    press(3'h1, K + 20);
    chk({6'h0, valve}, 8'h00);
  endtask : t_idle
  task automatic t_seq1();
    tune(3'h1);
    wait_v(2'h1, 10);
    chk(p1, CL);
    lit(0, 6 * F, F);
    wait_v(2'h0, V + 10);
    chk(p2, OP);
    repeat (A) @(posedge clk);
    chk({5'h0, taught}, 8'h03);
  endtask : t_seq1
  task automatic t_seq4();
    tune(3'h3);
    wait_v(2'h2, 10);
    wait_v(2'h1, V + 10);
    chk(p1, MI);
    wait_v(2'h2, V + 10);
    chk(p2, OP);
    wait_v(2'h0, A + 10);
    chk({5'h0, taught}, 8'h03);
  endtask : t_seq4
  task automatic t_seq5();
    tune(3'h5);
    wait_v(2'h1, 10);
    wait_v(2'h0, V + 10);
    wait_v(2'h2, A + 10);
    wait_v(2'h0, V + 10);
    chk(p3, MI);
    repeat (A) @(posedge clk);
    chk({5'h0, taught}, 8'h07);
  endtask : t_seq5
  task automatic t_timeout();
    stuck <= 1'b1;
    tune(3'h4);
    wait_v(2'h1, 10);
    wait_v(2'h0, V + 10);
    repeat (A - 20) @(posedge clk);
    chk({5'h0, taught}, 8'h07);
    repeat (30) @(posedge clk);
    chk({6'h0, valve}, 8'h00);
    chk({5'h0, taught}, 8'h04);
    stuck <= 1'b0;
  endtask : t_timeout
  task automatic t_double();
    dbl <= 1'b1;
    repeat (D + 4) @(posedge clk);
    tune(3'h4);
    chk({6'h0, valve}, 8'h00);
    press(3'h6, K + 20);
    chk({6'h0, valve}, 8'h00);
    press(3'h2, K + 20);
    wait_v(2'h1, 10);
    chk(p2, CL);
    wait_v(2'h0, V + 10);
    chk(p1, OP);
    repeat (A) @(posedge clk);
    chk({5'h0, taught}, 8'h07);
    dbl <= 1'b0;
  endtask : t_double
  // a fresh key during a run aborts it
  task automatic t_abort();
    tune(3'h1);
    press(3'h4, K);
    chk({6'h0, valve}, 8'h00);
    chk({5'h0, taught}, 8'h06);
  endtask : t_abort
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    repeat (D + 4) @(posedge clk);
    t_teach_a();
    t_teach_bc();
    t_clear();
    t_idle();
    t_seq1();
    t_seq4();
    t_seq5();
    t_timeout();
    t_double();
    t_abort();
    finish_test();
  end
endmodule : teach_button_autotune_sequencer_tb_top
